//--- hw/ats_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module ats_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin side
  input wire logic pin,
  // Synchronised result
  output logic level,
  output logic rise
);
  import ats_pkg::*;

  ats_sync_t st;
  ats_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 1'b0;
    // First stage feeds only the second; filter looks at stages two and three
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
      next_st.rise = st.s3 & ~st.level;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign rise = st.rise;
endmodule : ats_pin_sync

//--- hw/ats_pkg.sv
// Shared constants and carrier types for the asynchronous timer clock crossing
package ats_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0c;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_GEN_CTRL = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h20;
  // Index of each asynchronously written register; also its busy bit position
  localparam int IDX_CTRL_B = 0;
  localparam int IDX_CTRL_A = 1;
  localparam int IDX_CMP_B = 2;
  localparam int IDX_CMP_A = 3;
  localparam int IDX_COUNT = 4;
  localparam int NUM_ASYNC_REGS = 5;
  // Field positions
  localparam int POS_ASYNC_SEL = 5;
  localparam int POS_PRESC_RESET = 0;
  localparam int POS_CMP_A_TOGGLE = 6;
  localparam int POS_FLAG_OVF = 0;
  localparam int POS_FLAG_CMP_A = 1;
  localparam int POS_FLAG_CMP_B = 2;
  // Prescaler select codes in control B bits 2:0
  localparam logic [2:0] PSEL_STOP = 3'h0;
  localparam logic [2:0] PSEL_DIV1 = 3'h1;
  localparam logic [2:0] PSEL_DIV8 = 3'h2;
  localparam logic [2:0] PSEL_DIV32 = 3'h3;
  localparam logic [2:0] PSEL_DIV64 = 3'h4;
  localparam logic [2:0] PSEL_DIV128 = 3'h5;
  localparam logic [2:0] PSEL_DIV256 = 3'h6;
  localparam logic [2:0] PSEL_DIV1024 = 3'h7;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [9:0] RST_PRESC = 10'h000;
  // Timing counts
  localparam logic [1:0] COMMIT_EDGES = 2'h2;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam int OSC_FREQ_HZ = 32768;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ats_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ats_apb_rsp_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } ats_sync_t;
endpackage : ats_pkg

//--- hw/ats_timer_sync.sv
// Timer clock source, prescaler and processor/oscillator register crossing
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module ats_timer_sync #(
  parameter int COUNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input ats_pkg::ats_apb_req_t apb_req,
  output ats_pkg::ats_apb_rsp_t apb_rsp,
  // Oscillator pin and pin ownership
  input wire logic osc_in_pin,
  output logic osc_pins_release,
  output logic osc_run,
  // Sleep status from the power controller
  input wire logic sleep_active,
  input wire logic deep_sleep,
  // Timer results
  output logic compare_out,
  output logic [2:0] timer_flags,
  output logic wake_req
);
  import ats_pkg::*;

  typedef struct packed {
    logic [NUM_ASYNC_REGS-1:0][COUNT_W-1:0] dest;
    logic [NUM_ASYNC_REGS-1:0][COUNT_W-1:0] hold;
    logic [NUM_ASYNC_REGS-1:0] pend;
    logic [NUM_ASYNC_REGS-1:0] busy;
    logic [NUM_ASYNC_REGS-1:0][1:0] edges;
    logic [NUM_ASYNC_REGS-1:0] ack1;
    logic [NUM_ASYNC_REGS-1:0] ack2;
    logic async_sel;
    logic [9:0] presc;
    logic [COUNT_W-1:0] shadow;
    logic [FLAG_SYNC_CYCLES-1:0][2:0] fpipe;
    logic [2:0] flags;
    logic [2:0] irq_en;
    logic wake_pend;
    logic wake_req;
    logic cmp_out;
    logic [31:0] prdata;
    logic pslverr;
  } ats_state_t;

  ats_state_t st;
  ats_state_t next_st;
  logic osc_level;
  logic osc_rise;

  ats_pin_sync u_osc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(osc_in_pin),
    .level(osc_level),
    .rise(osc_rise)
  );

  // Mask of prescaler bits that must be all ones for a tick
  function automatic logic [9:0] presc_mask(input logic [2:0] sel);
    unique case (sel)
      PSEL_STOP: presc_mask = 10'h000;
      PSEL_DIV1: presc_mask = 10'h000;
      PSEL_DIV8: presc_mask = 10'h007;
      PSEL_DIV32: presc_mask = 10'h01f;
      PSEL_DIV64: presc_mask = 10'h03f;
      PSEL_DIV128: presc_mask = 10'h07f;
      PSEL_DIV256: presc_mask = 10'h0ff;
      PSEL_DIV1024: presc_mask = 10'h3ff;
    endcase
  endfunction : presc_mask

  // Register index for an async-written offset, or NUM_ASYNC_REGS if none
  function automatic int async_index(input logic [7:0] addr);
    unique case (addr)
      OFS_CTRL_A: async_index = IDX_CTRL_A;
      OFS_CTRL_B: async_index = IDX_CTRL_B;
      OFS_COUNT: async_index = IDX_COUNT;
      OFS_CMP_A: async_index = IDX_CMP_A;
      OFS_CMP_B: async_index = IDX_CMP_B;
      default: async_index = NUM_ASYNC_REGS;
    endcase
  endfunction : async_index

  logic src_edge;
  logic tick;
  logic match_a;
  logic match_b;
  logic ovf;
  logic [2:0] events;
  logic apb_wr;
  logic apb_setup;
  logic [COUNT_W-1:0] count;

  assign count = st.dest[IDX_COUNT];
  assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  // Async source edges are seen through the pin synchroniser; sync source is every edge
  assign src_edge = st.async_sel ? osc_rise : 1'b1;
  // Tick is a one-cycle enable, never a derived clock
  assign tick = src_edge & (st.dest[IDX_CTRL_B][2:0] != PSEL_STOP) &
                ((st.presc & presc_mask(st.dest[IDX_CTRL_B][2:0])) ==
                 presc_mask(st.dest[IDX_CTRL_B][2:0]));
  assign ovf = tick & (count == {COUNT_W{1'b1}});
  assign match_a = tick & (count == st.dest[IDX_CMP_A]) &
                   ~st.busy[IDX_CMP_A] & ~st.busy[IDX_COUNT];
  assign match_b = tick & (count == st.dest[IDX_CMP_B]) &
                   ~st.busy[IDX_CMP_B] & ~st.busy[IDX_COUNT];
  assign events = {match_b, match_a, ovf};

  always_comb begin
    int idx;
    logic [2:0] flag_set;
    idx = async_index(apb_req.paddr);
    flag_set = 3'h0;
    next_st = st;
    next_st.ack1 = '0;
    next_st.ack2 = st.ack1;
    next_st.presc = src_edge ? 10'(st.presc + 10'h001) : st.presc;
    if (tick) begin
      next_st.dest[IDX_COUNT] = COUNT_W'(count + 1'b1);
    end
    if (match_a && st.dest[IDX_CTRL_A][POS_CMP_A_TOGGLE]) begin
      next_st.cmp_out = ~st.cmp_out;
    end
    // Commit held values on the second oscillator edge
    for (int i = 0; i < NUM_ASYNC_REGS; i++) begin
      if (st.pend[i] && osc_rise) begin
        next_st.edges[i] = 2'(st.edges[i] + 2'h1);
        if (2'(st.edges[i] + 2'h1) == COMMIT_EDGES) begin
          next_st.dest[i] = st.hold[i];
          next_st.pend[i] = 1'b0;
          next_st.edges[i] = 2'h0;
          next_st.ack1[i] = 1'b1;
        end
      end
      // A write below in the same cycle sets busy again and wins
      if (st.ack2[i]) begin
        next_st.busy[i] = 1'b0;
      end
    end
    // Shadow lags the counter by one oscillator edge
    if (st.async_sel && osc_rise) begin
      next_st.shadow = count;
    end
    // Async flags cross through a short pipeline; sync flags set at once
    next_st.fpipe[0] = st.async_sel ? events : 3'h0;
    for (int s = 1; s < FLAG_SYNC_CYCLES; s++) begin
      next_st.fpipe[s] = st.fpipe[s-1];
    end
    flag_set = st.async_sel ? st.fpipe[FLAG_SYNC_CYCLES-1] : events;
    if (sleep_active && st.async_sel && |(events & st.irq_en)) begin
      next_st.wake_pend = 1'b1;
    end
    if (st.wake_pend && src_edge) begin
      next_st.wake_req = 1'b1;
      next_st.wake_pend = 1'b0;
    end
    if (!sleep_active) begin
      next_st.wake_req = 1'b0;
      next_st.wake_pend = 1'b0;
    end
    // Register writes at the APB access phase
    if (apb_wr) begin
      if (idx < NUM_ASYNC_REGS) begin
        if (st.async_sel) begin
          // Only this register's holding slot is touched
          next_st.hold[idx] = apb_req.pwdata[COUNT_W-1:0];
          next_st.pend[idx] = 1'b1;
          next_st.edges[idx] = 2'h0;
          next_st.busy[idx] = 1'b1;
        end else begin
          next_st.dest[idx] = apb_req.pwdata[COUNT_W-1:0];
        end
      end
      unique case (apb_req.paddr)
        OFS_STATUS: next_st.async_sel = apb_req.pwdata[POS_ASYNC_SEL];
        OFS_GEN_CTRL: begin
          if (apb_req.pwdata[POS_PRESC_RESET]) begin
            next_st.presc = RST_PRESC;
          end
        end
        OFS_FLAGS: next_st.flags = st.flags & ~apb_req.pwdata[2:0];
        OFS_IRQ_EN: next_st.irq_en = apb_req.pwdata[2:0];
        default: next_st.flags = st.flags;
      endcase
    end
    // A flag event in the clearing cycle still lands
    next_st.flags = next_st.flags | flag_set;
    // Read data is prepared in the setup cycle
    if (apb_setup) begin
      next_st.prdata = 32'h0;
      next_st.pslverr = 1'b0;
      unique case (apb_req.paddr)
        OFS_CTRL_A: next_st.prdata[7:0] = st.dest[IDX_CTRL_A];
        OFS_CTRL_B: next_st.prdata[7:0] = st.dest[IDX_CTRL_B];
        OFS_COUNT: next_st.prdata[7:0] = st.async_sel ? st.shadow : count;
        OFS_CMP_A: next_st.prdata[7:0] = st.dest[IDX_CMP_A];
        OFS_CMP_B: next_st.prdata[7:0] = st.dest[IDX_CMP_B];
        OFS_STATUS: begin
          next_st.prdata[NUM_ASYNC_REGS-1:0] = st.busy;
          next_st.prdata[POS_ASYNC_SEL] = st.async_sel;
        end
        OFS_GEN_CTRL: next_st.prdata = 32'h0;
        OFS_FLAGS: next_st.prdata[2:0] = st.flags;
        OFS_IRQ_EN: next_st.prdata[2:0] = st.irq_en;
        default: next_st.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Every access completes without wait states
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = st.pslverr & apb_req.psel & apb_req.penable;
  assign apb_rsp.prdata = st.prdata;
  assign osc_pins_release = st.async_sel;
  assign osc_run = st.async_sel & ~deep_sleep;
  assign compare_out = st.cmp_out;
  assign timer_flags = st.flags;
  assign wake_req = st.wake_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Antecedents below are ones the bench scenarios reach
  a_pins_follow_sel: assert property (apb_wr && apb_req.paddr == OFS_STATUS |=>
      osc_pins_release == $past(apb_req.pwdata[POS_ASYNC_SEL]))
    else $error("pin release does not follow async select write");
  a_stop_no_tick: assert property (st.dest[IDX_CTRL_B][2:0] == PSEL_STOP |-> !tick)
    else $error("tick while prescaler stopped");
  a_div8_spacing: assert property (!st.async_sel && tick &&
      st.dest[IDX_CTRL_B][2:0] == PSEL_DIV8 && !apb_wr ##1
      (st.dest[IDX_CTRL_B][2:0] == PSEL_DIV8 && !apb_wr) [*6] |-> !tick)
    else $error("divide by eight ticked early");
  a_presc_reset: assert property (apb_wr && apb_req.paddr == OFS_GEN_CTRL &&
      apb_req.pwdata[POS_PRESC_RESET] |=> st.presc == RST_PRESC)
    else $error("prescaler not reset");
  a_busy_on_write: assert property (apb_wr && st.async_sel &&
      apb_req.paddr == OFS_CMP_A |=> st.busy[IDX_CMP_A] && st.pend[IDX_CMP_A])
    else $error("busy not set on async write");
  // First oscillator edge after a write must leave the destination alone
  a_no_early_commit: assert property (st.pend[IDX_CMP_A] && osc_rise &&
      st.edges[IDX_CMP_A] == 2'h0 && !apb_wr |=>
      st.pend[IDX_CMP_A] && $stable(st.dest[IDX_CMP_A]))
    else $error("commit before two oscillator edges");
  a_held_write: assert property (apb_wr && st.async_sel &&
      apb_req.paddr == OFS_COUNT && !osc_rise |=> $stable(st.dest[IDX_COUNT]))
    else $error("async counter write reached the counter at once");
  a_sync_direct: assert property (apb_wr && !st.async_sel &&
      apb_req.paddr == OFS_CMP_A |=> st.dest[IDX_CMP_A] == $past(apb_req.pwdata[COUNT_W-1:0]))
    else $error("sync write did not land directly");
  // Busy drops two cycles after the commit acknowledge appears
  a_busy_clear_lag: assert property ($rose(st.ack1[IDX_COUNT]) && !apb_wr ##1
      !apb_wr |-> st.busy[IDX_COUNT] ##1 !st.busy[IDX_COUNT])
    else $error("busy clear not two cycles after commit");
  a_match_suppress: assert property (st.busy[IDX_COUNT] |-> !match_a && !match_b)
    else $error("compare match while counter write pending");
  a_flag_latency: assert property (st.async_sel && ovf ##1 st.async_sel [*3] |=>
      st.flags[POS_FLAG_OVF])
    else $error("async flag not set four cycles after the event");
  a_shadow_hold: assert property (st.async_sel && !osc_rise |=> $stable(st.shadow))
    else $error("shadow changed without oscillator edge");
  a_cmp_out_tick: assert property (!tick |=> $stable(compare_out))
    else $error("compare output moved without tick");
  a_wake_on_tick: assert property ($rose(wake_req) |-> $past(src_edge))
    else $error("wake not aligned to timer clock");

  // Coverage of the main scenarios
  c_async_commit: cover property (st.ack2[IDX_COUNT]);
  c_async_flag: cover property (st.async_sel && st.flags[POS_FLAG_OVF]);
  c_wake: cover property ($rose(wake_req));
  c_div1024: cover property (tick && st.dest[IDX_CTRL_B][2:0] == PSEL_DIV1024);
  c_match_held_off: cover property (tick && st.busy[IDX_CMP_A]);
endmodule : ats_timer_sync

//--- tb/ats_osc_model.sv
// Behavioural crystal oscillator driving the timer oscillator pin
`timescale 1ns/1ns
module ats_osc_model #(
  // Odd half period keeps the pin out of phase with the system clock
  parameter int HALF_NS = 203
) (
  // Enable from the device
  input wire logic run,
  // Oscillator pin
  output logic osc
);
  // Period of about 41 system clocks keeps the system clock over four times faster
  initial begin
    osc = 1'b0;
    forever begin
      #HALF_NS;
      // Stopped oscillator stands low, no edges to count
      if (run)
        osc = ~osc;
      else
        osc = 1'b0;
    end
  end
endmodule : ats_osc_model

//--- tb/ats_timer_sync_bench.sv
// Self-checking bench for the timer clock source and register crossing
`timescale 1ns/1ns
module ats_timer_sync_bench;
  import ats_pkg::*;
  logic clk;
  logic rst_n;
  ats_apb_req_t req;
  ats_apb_rsp_t rsp;
  logic osc_pin;
  logic pins_rel;
  logic osc_run;
  logic sleep_active;
  logic deep_sleep;
  logic cmp_out;
  logic [2:0] flags;
  logic wake;
  logic [31:0] q;
  int err_total = 0;
  int checks_done = 0;
  int dv [7] = '{1, 8, 32, 64, 128, 256, 1024};

  ats_timer_sync uut (
    .clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .osc_in_pin(osc_pin), .osc_pins_release(pins_rel), .osc_run(osc_run),
    .sleep_active(sleep_active), .deep_sleep(deep_sleep),
    .compare_out(cmp_out), .timer_flags(flags), .wake_req(wake)
  );

  ats_osc_model osc (.run(osc_run), .osc(osc_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Poll status until no holding register is pending, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS);
      n++;
    end while (q[4:0] !== 5'h0 && n < 300);
    chk({27'h0, q[4:0]}, 32'h0);
  endtask : wait_idle

  task automatic summarize();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // Run is near 7.5k cycles; the limit leaves wide margin
  initial begin
    #600000;
    err_total++;
    summarize();
  end

  initial begin
    int n;
    rst_n = 1'b0;
    req = '0;
    sleep_active = 1'b0;
    deep_sleep = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_STATUS);
    chk(q, 32'h0);
    chk({31'h0, pins_rel}, 32'h0);
    // Stopped prescaler leaves the count alone
    wr(OFS_CTRL_B, {29'h0, PSEL_STOP});
    wr(OFS_COUNT, 32'h5);
    repeat (20) @(posedge clk);
    rd(OFS_COUNT);
    chk(q, 32'h5);
    // Each divider from a freshly reset prescaler: four ticks, five at divide by one
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CTRL_B, 32'(i + 1));
      wr(OFS_GEN_CTRL, 32'h1);
      wr(OFS_COUNT, 32'h0);
      repeat (4 * dv[i]) @(posedge clk);
      rd(OFS_COUNT);
      chk(q, (i == 0) ? 32'h5 : 32'h4);
    end
    // Synchronous compare A match toggles the pin once in 30 cycles
    wr(OFS_CTRL_B, {29'h0, PSEL_STOP});
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CMP_A, 32'h10);
    wr(OFS_CTRL_A, 32'h40);
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL_B, {29'h0, PSEL_DIV1});
    repeat (30) @(posedge clk);
    chk({31'h0, flags[1]}, 32'h1);
    chk({31'h0, cmp_out}, 32'h1);
    wr(OFS_FLAGS, 32'h2);
    rd(OFS_FLAGS);
    chk({31'h0, q[1]}, 32'h0);
    // Switch to the oscillator in the safe order
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_STATUS, 32'h20);
    repeat (2) @(posedge clk);
    chk({31'h0, pins_rel}, 32'h1);
    chk({31'h0, osc_run}, 32'h1);
    // Scaled settle time for the oscillator before async use
    repeat (2) @(posedge osc_pin);
    wr(OFS_CTRL_B, {29'h0, PSEL_STOP});
    wait_idle();
    wr(OFS_CMP_A, 32'h33);
    rd(OFS_STATUS);
    chk(q, 32'h28);
    wr(OFS_COUNT, 32'h42);
    rd(OFS_STATUS);
    chk(q, 32'h38);
    wait_idle();
    repeat (100) @(posedge clk);
    rd(OFS_COUNT);
    chk(q, 32'h42);
    // Overflow wakes the sleeping core
    wr(OFS_COUNT, 32'hf0);
    wait_idle();
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_CTRL_B, {29'h0, PSEL_DIV1});
    wait_idle();
    sleep_active <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wake !== 1'b1 && n < 1000);
    chk({31'h0, wake}, 32'h1);
    chk({31'h0, flags[0]}, 32'h1);
    sleep_active <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, wake}, 32'h0);
    // After wake: busy clear first, then the shadow shows the wrapped count
    wait_idle();
    rd(OFS_COUNT);
    chk(q, 32'h0);
    deep_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, osc_run}, 32'h0);
    summarize();
  end
endmodule : ats_timer_sync_bench
